//--- inc/txq_pkg.sv
// constants and types shared by the timestamped transmit queue
package txq_pkg;
  // queue sizes
  localparam int unsigned QUEUE_DEPTH = 1024;
  localparam int unsigned STAGE_DEPTH = 32;
  localparam int unsigned BATCH_MAX   = 512;
  localparam int unsigned CNT_W       = 11;
  // entry field widths and batch status width
  localparam int unsigned KIND_W = 8;
  localparam int unsigned ID_W   = 32;
  localparam int unsigned LEN_W  = 8;
  localparam int unsigned DATA_W = 64;
  localparam int unsigned TS_W   = 64;
  localparam int unsigned STAT_W = 32;
  // entry layout: {kind, id, len, data, ts}
  localparam int unsigned TS_LSB   = 0;
  localparam int unsigned DATA_LSB = TS_LSB + TS_W;
  localparam int unsigned LEN_LSB  = DATA_LSB + DATA_W;
  localparam int unsigned ID_LSB   = LEN_LSB + LEN_W;
  localparam int unsigned KIND_LSB = ID_LSB + ID_W;
  localparam int unsigned ENTRY_W  = KIND_LSB + KIND_W;
  // frame handed to the network: entry without timestamp
  localparam int unsigned FRAME_W  = ENTRY_W - TS_W;
  // frame kinds
  localparam logic [7:0] KIND_PAYLOAD = 8'h00;
  localparam logic [7:0] KIND_REQUEST = 8'h01;
  localparam logic [7:0] KIND_START   = 8'h04;
  // pacing modes
  localparam logic MODE_IMMEDIATE   = 1'b0;
  localparam logic MODE_TIMESTAMPED = 1'b1;
  // batch status codes, signed
  localparam logic [31:0] STAT_OK        = 32'h0000_0000;
  localparam logic [31:0] STAT_WARN_LOW  = 32'h0000_0001;
  localparam logic [31:0] STAT_ERR_OVFL  = 32'hFFFF_FFFF;
  localparam logic [31:0] STAT_ERR_SIZE  = 32'hFFFF_FFFE;
  localparam logic [31:0] STAT_ERR_BUSY  = 32'hFFFF_FFFD;
  // timing: one timestamp unit and the clock period
  localparam int unsigned TS_UNIT_NS    = 100;
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned TICK_RAW      = TS_UNIT_NS / CLK_PERIOD_NS;
  localparam int unsigned TICK_CYCLES   = (TICK_RAW < 1) ? 1 : TICK_RAW;
  localparam int unsigned TICK_W        = 8;
  // scheduler states, one-hot
  typedef enum logic [3:0] {
    S_IDLE = 4'h1,
    S_GAP  = 4'h2,
    S_PUSH = 4'h4,
    S_HOLD = 4'h8
  } sched_t;
endpackage

//--- rtl/txq_top.sv
// timestamped transmit queue with batch admission and pacing
`timescale 1ns/1ns

// generic first-in first-out buffer held in flip-flops
module txq_fifo #(
  parameter int unsigned W     = 8,
  parameter int unsigned DEPTH = 32
) (
  // clock and reset
  input  wire logic                       clk_i,
  input  wire logic                       srst_i,
  // filling side
  input  wire logic                       in_valid_i,
  output      logic                       in_ready_o,
  input  wire logic [W-1:0]               in_data_i,
  // draining side
  output      logic                       out_valid_o,
  input  wire logic                       out_ready_i,
  output      logic [W-1:0]               out_data_o,
  // fill level
  output      logic [$clog2(DEPTH):0]     count_o
);
  localparam int unsigned AW = $clog2(DEPTH);

  // whole fifo state
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;  // storage words
    logic [AW-1:0]           wr;   // write index
    logic [AW-1:0]           rd;   // read index
    logic [AW:0]             cnt;  // words held
  } fifo_state_t;

  fifo_state_t q;  // registered state
  fifo_state_t d;  // next state
  logic        push;
  logic        pop;

  // handshakes from the fill level
  assign in_ready_o  = (q.cnt != (AW+1)'(DEPTH));
  assign out_valid_o = (q.cnt != '0);
  assign out_data_o  = q.mem[q.rd];
  assign count_o     = q.cnt;
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;

  // next state: write, read and level
  always_comb begin
    d = q;
    if (push) begin
      d.mem[q.wr] = in_data_i;
      d.wr        = q.wr + 1'b1;
    end
    if (pop) begin
      d.rd = q.rd + 1'b1;
    end
    case ({push, pop})
      2'b10:   d.cnt = q.cnt + 1'b1;
      2'b01:   d.cnt = q.cnt - 1'b1;
      default: d.cnt = q.cnt;
    endcase
  end

  // state register
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
endmodule

// top: batch admission, write queue, pacing scheduler, staging
module txq_top (
  // clock and reset
  input  wire logic                        SYS_CLK_I,
  input  wire logic                        SRST_I,
  // configuration
  input  wire logic                        TX_PACING_SELECT_I,
  // batch request and answer
  input  wire logic                        BATCH_START_I,
  input  wire logic [txq_pkg::CNT_W-1:0]   BATCH_COUNT_I,
  output      logic [txq_pkg::STAT_W-1:0]  BATCH_STATUS_O,
  output      logic                        BATCH_STATUS_VALID_O,
  // entry stream of an accepted batch
  input  wire logic                        ENTRY_VALID_I,
  output      logic                        ENTRY_READY_O,
  input  wire logic [txq_pkg::KIND_W-1:0]  ENTRY_KIND_I,
  input  wire logic [txq_pkg::ID_W-1:0]    ENTRY_ID_I,
  input  wire logic [txq_pkg::LEN_W-1:0]   ENTRY_LEN_I,
  input  wire logic [txq_pkg::DATA_W-1:0]  ENTRY_DATA_I,
  input  wire logic [txq_pkg::TS_W-1:0]    ENTRY_TS_I,
  // frames to the network engine
  output      logic                        TX_VALID_O,
  input  wire logic                        TX_READY_I,
  output      logic [txq_pkg::KIND_W-1:0]  TX_KIND_O,
  output      logic [txq_pkg::ID_W-1:0]    TX_ID_O,
  output      logic [txq_pkg::LEN_W-1:0]   TX_LEN_O,
  output      logic [txq_pkg::DATA_W-1:0]  TX_DATA_O,
  // status
  output      logic                        BATCH_SPACE_FLAG_O,
  output      logic [txq_pkg::CNT_W-1:0]   FREE_ENTRY_COUNT_O,
  output      logic                        TX_DONE_FLAG_O,
  output      logic                        TX_PACING_SELECT_O
);
  import txq_pkg::*;

  // whole block state
  typedef struct packed {
    logic               mode;      // pacing select in use
    logic [CNT_W-1:0]   remain;    // entries still owed by batch
    logic [STAT_W-1:0]  status;    // last batch answer
    logic               stat_v;    // answer strobe
    logic               space;     // batch space flag
    logic [CNT_W-1:0]   free;      // free entry count
    sched_t             sched;     // scheduler state
    logic [FRAME_W-1:0] cur;       // frame being paced
    logic [TS_W-1:0]    gap;       // ticks left before send
    logic [TS_W-1:0]    prev_ts;   // timeline reference
    logic               first;     // next frame opens a sequence
    logic               sent_any;  // a frame left since last batch
    logic               done;      // transmit complete
    logic [TICK_W-1:0]  tick_cnt;  // timestamp unit divider
  } txq_state_t;

  txq_state_t q;  // registered state
  txq_state_t d;  // next state

  // write queue wiring
  logic               wq_in_valid;
  logic               wq_in_ready;
  logic [ENTRY_W-1:0] wq_in_data;
  logic               wq_out_valid;
  logic               wq_out_ready;
  logic [ENTRY_W-1:0] wq_out_data;
  logic [CNT_W-1:0]   wq_count;
  // staging fifo wiring
  logic               st_in_valid;
  logic               st_in_ready;
  logic               st_out_valid;
  logic [FRAME_W-1:0] st_out_data;
  logic [$clog2(STAGE_DEPTH):0] st_count;
  // decoded head entry
  logic [KIND_W-1:0]  hd_kind;
  logic [TS_W-1:0]    hd_ts;
  logic [FRAME_W-1:0] hd_frame;
  // helpers
  logic [CNT_W-1:0]   free_now;
  logic               tick;

  // entry packing in queue order
  assign wq_in_data = {ENTRY_KIND_I, ENTRY_ID_I, ENTRY_LEN_I,
                       ENTRY_DATA_I, ENTRY_TS_I};
  // the stream is open only while a batch owes entries
  assign wq_in_valid   = ENTRY_VALID_I & (q.remain != '0);
  assign ENTRY_READY_O = wq_in_ready & (q.remain != '0);
  // head entry fields
  assign hd_kind  = wq_out_data[KIND_LSB +: KIND_W];
  assign hd_ts    = wq_out_data[TS_LSB +: TS_W];
  assign hd_frame = wq_out_data[ENTRY_W-1:TS_W];
  // scheduler takes the head only when idle
  assign wq_out_ready = (q.sched == S_IDLE);
  assign st_in_valid  = (q.sched == S_PUSH);
  // free entries: space minus held and reserved
  assign free_now = CNT_W'(QUEUE_DEPTH) - wq_count - q.remain;
  // one pulse per timestamp unit
  assign tick = (q.tick_cnt == TICK_W'(TICK_CYCLES - 1));

  // one write queue keeps enqueue order
  txq_fifo #(
    .W     (ENTRY_W),
    .DEPTH (QUEUE_DEPTH)
  ) u_write_queue (
    .clk_i       (SYS_CLK_I),
    .srst_i      (SRST_I),
    .in_valid_i  (wq_in_valid),
    .in_ready_o  (wq_in_ready),
    .in_data_i   (wq_in_data),
    .out_valid_o (wq_out_valid),
    .out_ready_i (wq_out_ready),
    .out_data_o  (wq_out_data),
    .count_o     (wq_count)
  );

  // staging buffer toward the network engine
  txq_fifo #(
    .W     (FRAME_W),
    .DEPTH (STAGE_DEPTH)
  ) u_stage (
    .clk_i       (SYS_CLK_I),
    .srst_i      (SRST_I),
    .in_valid_i  (st_in_valid),
    .in_ready_o  (st_in_ready),
    .in_data_i   (q.cur),
    .out_valid_o (st_out_valid),
    .out_ready_i (TX_READY_I),
    .out_data_o  (st_out_data),
    .count_o     (st_count)
  );

  // network side outputs straight from staging storage
  assign TX_VALID_O = st_out_valid;
  assign TX_KIND_O  = st_out_data[FRAME_W-1 -: KIND_W];
  assign TX_ID_O    = st_out_data[ID_LSB-TS_W +: ID_W];
  assign TX_LEN_O   = st_out_data[LEN_LSB-TS_W +: LEN_W];
  assign TX_DATA_O  = st_out_data[DATA_LSB-TS_W +: DATA_W];
  // status outputs from registers
  assign BATCH_STATUS_O       = q.status;
  assign BATCH_STATUS_VALID_O = q.stat_v;
  assign BATCH_SPACE_FLAG_O   = q.space;
  assign FREE_ENTRY_COUNT_O   = q.free;
  assign TX_DONE_FLAG_O       = q.done;
  assign TX_PACING_SELECT_O   = q.mode;

  // next state of admission, scheduler and status
  always_comb begin
    d        = q;
    d.stat_v = 1'b0;
    // pacing select follows the control port
    d.mode   = TX_PACING_SELECT_I;
    // timestamp unit divider
    if (tick) begin
      d.tick_cnt = '0;
    end else begin
      d.tick_cnt = q.tick_cnt + 1'b1;
    end

    // batch admission, answered the next cycle
    if (BATCH_START_I) begin
      d.stat_v = 1'b1;
      if (q.remain != '0) begin
        // previous batch still streaming
        d.status = STAT_ERR_BUSY;
      end else if ((BATCH_COUNT_I == '0) ||
                   (BATCH_COUNT_I > CNT_W'(BATCH_MAX))) begin
        d.status = STAT_ERR_SIZE;
      end else if (BATCH_COUNT_I > free_now) begin
        d.status = STAT_ERR_OVFL;
      end else begin
        d.remain   = BATCH_COUNT_I;
        d.sent_any = 1'b0;
        if ((free_now - BATCH_COUNT_I) < CNT_W'(BATCH_MAX)) begin
          d.status = STAT_WARN_LOW;
        end else begin
          d.status = STAT_OK;
        end
      end
    end
    // owed entry delivered; a busy refusal must not swallow it
    if (wq_in_valid & wq_in_ready) begin
      d.remain = q.remain - 1'b1;
    end

    // scheduler
    case (q.sched)
      S_IDLE: begin
        if (wq_out_valid) begin
          case (hd_kind)
            KIND_START: begin
              d.prev_ts = '0;
              d.first   = 1'b0;
            end
            KIND_PAYLOAD, KIND_REQUEST: begin
              d.cur = hd_frame;
              if (hd_kind == KIND_REQUEST) begin
                d.cur[DATA_LSB-TS_W +: DATA_W] = '0;
              end
              if ((q.mode == MODE_IMMEDIATE) || q.first) begin
                d.gap = '0;
              end else if (hd_ts < q.prev_ts) begin
                d.gap = '0;
              end else begin
                d.gap = hd_ts - q.prev_ts;
              end
              d.prev_ts = hd_ts;
              d.first   = 1'b0;
              d.sched   = S_GAP;
            end
            default: begin
              // unknown kinds are dropped
              d.sched = S_IDLE;
            end
          endcase
        end else if (q.remain == '0) begin
          // drained: next frame opens a new sequence
          d.first = 1'b1;
        end
      end
      S_GAP: begin
        // count down whole timestamp units
        if (q.gap == '0) begin
          d.sched = S_PUSH;
        end else if (tick) begin
          d.gap = q.gap - 1'b1;
        end
      end
      S_PUSH: begin
        // stalls while staging is full
        if (st_in_ready) begin
          d.sent_any = 1'b1;
          d.sched    = S_HOLD;
        end
      end
      S_HOLD: begin
        // one settle cycle so staging level is seen
        d.sched = S_IDLE;
      end
      default: begin
        d.sched = S_IDLE;
      end
    endcase

    d.free  = free_now;
    d.space = (free_now >= CNT_W'(BATCH_MAX));
    // done once queue, pacer and staging drain
    d.done  = q.sent_any & (q.sched == S_IDLE) & ~wq_out_valid &
              (st_count == '0) & (q.remain == '0);
  end

  // state register
  always_ff @(posedge SYS_CLK_I) begin
    if (SRST_I) begin
      q        <= '0;
      q.mode   <= MODE_IMMEDIATE;
      q.sched  <= S_IDLE;
      q.first  <= 1'b1;
      q.status <= STAT_OK;
    end else begin
      q <= d;
    end
  end
endmodule

//--- tb/txq_properties.sv
// port assertions for the timestamped transmit queue
`timescale 1ns/1ns
module txq_properties (
  // clock and reset
  input wire logic                       SYS_CLK_I,
  input wire logic                       SRST_I,
  // batch side
  input wire logic                       TX_PACING_SELECT_I,
  input wire logic                       BATCH_START_I,
  input wire logic [txq_pkg::CNT_W-1:0]  BATCH_COUNT_I,
  input wire logic [txq_pkg::STAT_W-1:0] BATCH_STATUS_O,
  input wire logic                       BATCH_STATUS_VALID_O,
  input wire logic                       ENTRY_READY_O,
  // network side
  input wire logic                       TX_VALID_O,
  input wire logic                       TX_READY_I,
  input wire logic [txq_pkg::KIND_W-1:0] TX_KIND_O,
  input wire logic [txq_pkg::ID_W-1:0]   TX_ID_O,
  input wire logic [txq_pkg::DATA_W-1:0] TX_DATA_O,
  // status
  input wire logic                       BATCH_SPACE_FLAG_O,
  input wire logic [txq_pkg::CNT_W-1:0]  FREE_ENTRY_COUNT_O,
  input wire logic                       TX_DONE_FLAG_O,
  input wire logic                       TX_PACING_SELECT_O
);
  import txq_pkg::*;
  default clocking dc @(posedge SYS_CLK_I); endclocking
  default disable iff (SRST_I);
  answer_next_a :
    assert property (BATCH_START_I |=> BATCH_STATUS_VALID_O)
    else $error("start pulse not answered next cycle");
  no_stray_a :
    assert property (!BATCH_START_I |=> !BATCH_STATUS_VALID_O)
    else $error("status pulse without a start");
  mode_copy_a :
    assert property (!$past(SRST_I) |->
      TX_PACING_SELECT_O == $past(TX_PACING_SELECT_I))
    else $error("mode copy wrong");
  size_refuse_a :
    assert property (BATCH_START_I && (BATCH_COUNT_I > BATCH_MAX ||
      BATCH_COUNT_I == 0) |=> BATCH_STATUS_O[31])
    else $error("bad batch size not refused");
  space_flag_a :
    assert property (BATCH_SPACE_FLAG_O == (FREE_ENTRY_COUNT_O >= 512))
    else $error("space flag disagrees with free count");
  stream_open_a :
    assert property (BATCH_STATUS_VALID_O && !BATCH_STATUS_O[31]
      |-> ENTRY_READY_O)
    else $error("accepted batch not opened");
  refuse_closed_a :
    assert property (BATCH_STATUS_VALID_O && (BATCH_STATUS_O == STAT_ERR_OVFL
      || BATCH_STATUS_O == STAT_ERR_SIZE) |-> !ENTRY_READY_O)
    else $error("refused batch opened the stream");
  frame_hold_a :
    assert property (TX_VALID_O && !TX_READY_I |=> TX_VALID_O &&
      $stable(TX_ID_O) && $stable(TX_KIND_O))
    else $error("frame changed before taken");
  done_idle_a :
    assert property (TX_DONE_FLAG_O |-> !TX_VALID_O)
    else $error("done while frame pending");
  request_empty_a :
    assert property (TX_VALID_O && TX_KIND_O == KIND_REQUEST
      |-> TX_DATA_O == '0)
    else $error("request frame carries data");
  marker_kept_a :
    assert property (TX_VALID_O |-> TX_KIND_O != KIND_START)
    else $error("start marker sent");
endmodule
bind txq_top txq_properties chk (.SYS_CLK_I, .SRST_I, .TX_PACING_SELECT_I,
  .BATCH_START_I, .BATCH_COUNT_I, .BATCH_STATUS_O, .BATCH_STATUS_VALID_O,
  .ENTRY_READY_O, .TX_VALID_O, .TX_READY_I, .TX_KIND_O, .TX_ID_O,
  .TX_DATA_O, .BATCH_SPACE_FLAG_O, .FREE_ENTRY_COUNT_O, .TX_DONE_FLAG_O,
  .TX_PACING_SELECT_O);

//--- tb/txq_net_model.sv
// network engine model: takes frames, may stall, logs arrivals
`timescale 1ns/1ns
module txq_net_model (
  input  wire logic                     clk_i,
  input  wire logic                     stall_i,
  input  wire logic                     valid_i,
  output      logic                     ready_o,
  input  wire logic [txq_pkg::ID_W-1:0] id_i,
  input  wire logic [txq_pkg::LEN_W-1:0]  len_i,
  input  wire logic [txq_pkg::DATA_W-1:0] data_i
);
  import txq_pkg::*;
  int          cyc = 0; // cycle counter
  logic [31:0] ids[$];  // frame ids in arrival order
  int          tms[$];  // arrival cycle of each frame
  logic [7:0]  lens[$]; // length field of each frame
  logic [63:0] dat[$];  // data field of each frame
  // back-pressure follows the bench
  assign ready_o = !stall_i;
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (valid_i && ready_o) begin
      ids.push_back(id_i);
      tms.push_back(cyc);
      lens.push_back(len_i);
      dat.push_back(data_i);
    end
  end
endmodule

//--- tb/txq_top_tb.sv
// self-checking bench for the timestamped transmit queue
`timescale 1ns/1ns
module txq_top_tb;
  import txq_pkg::*;
  logic              SYS_CLK_I = 1'b0, SRST_I = 1'b1, stall = 1'b1;
  logic              TX_PACING_SELECT_I = 1'b0, BATCH_START_I = 1'b0;
  logic [CNT_W-1:0]  BATCH_COUNT_I = '0, FREE_ENTRY_COUNT_O;
  logic [STAT_W-1:0] BATCH_STATUS_O;
  logic              BATCH_STATUS_VALID_O, ENTRY_VALID_I = 1'b0;
  logic [KIND_W-1:0] ENTRY_KIND_I = '0, TX_KIND_O;
  logic [ID_W-1:0]   ENTRY_ID_I = '0, TX_ID_O, exp_ids[$];
  logic [LEN_W-1:0]  ENTRY_LEN_I = 8'h08, TX_LEN_O;
  logic [DATA_W-1:0] ENTRY_DATA_I = '0, TX_DATA_O, exp_dat[$];
  logic [TS_W-1:0]   ENTRY_TS_I = '0;
  logic              ENTRY_READY_O, TX_VALID_O, TX_READY_I;
  logic              BATCH_SPACE_FLAG_O, TX_DONE_FLAG_O, TX_PACING_SELECT_O;
  int                fails = 0, cmp_count = 0, nexp = 0, t0, d, f;
  // free-running clock
  always #50 SYS_CLK_I = ~SYS_CLK_I;
  txq_top DUT (.SYS_CLK_I, .SRST_I, .TX_PACING_SELECT_I, .BATCH_START_I,
    .BATCH_COUNT_I, .BATCH_STATUS_O, .BATCH_STATUS_VALID_O, .ENTRY_VALID_I,
    .ENTRY_READY_O, .ENTRY_KIND_I, .ENTRY_ID_I, .ENTRY_LEN_I, .ENTRY_DATA_I,
    .ENTRY_TS_I, .TX_VALID_O, .TX_READY_I, .TX_KIND_O, .TX_ID_O, .TX_LEN_O,
    .TX_DATA_O, .BATCH_SPACE_FLAG_O, .FREE_ENTRY_COUNT_O, .TX_DONE_FLAG_O,
    .TX_PACING_SELECT_O);
  txq_net_model net (.clk_i(SYS_CLK_I), .stall_i(stall),
    .valid_i(TX_VALID_O), .ready_o(TX_READY_I), .id_i(TX_ID_O),
    .len_i(TX_LEN_O), .data_i(TX_DATA_O));
  task automatic tick(input int n = 1);
    repeat (n) @(posedge SYS_CLK_I);
    #1;
  endtask
  task automatic check(input string what, input logic [63:0] got, exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("mismatch %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic finish_test();
    $display("fails %0d cmp_count %0d", fails, cmp_count);
    if (fails == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic give_up();
    check("bounded_wait", 0, 1);
    finish_test();
  endtask
  // one batch request and its answer
  task automatic req(input int n, input logic [31:0] exp);
    BATCH_START_I = 1'b1;
    BATCH_COUNT_I = n[CNT_W-1:0];
    tick();
    BATCH_START_I = 1'b0;
    check("status_valid", BATCH_STATUS_VALID_O, 1);
    check("status", BATCH_STATUS_O, exp);
    tick();
  endtask
  // one entry, held until taken
  task automatic put(input logic [7:0] k, input int id, input longint ts);
    int w;
    w = 0;
    ENTRY_VALID_I = 1'b1;
    ENTRY_KIND_I = k;
    ENTRY_ID_I = id;
    ENTRY_DATA_I = {2{id}};
    ENTRY_TS_I = ts;
    // only payload and request kinds reach the network
    if (k == KIND_PAYLOAD || k == KIND_REQUEST) begin
      exp_ids.push_back(id);
      exp_dat.push_back((k == KIND_REQUEST) ? 64'h0 : {2{id}});
    end
    while (ENTRY_READY_O !== 1'b1) begin
      if (++w > 200) give_up();
      tick();
    end
    tick();
  endtask
  task automatic feed(input int n, input int base);
    for (int i = 0; i < n; i++) put(KIND_PAYLOAD, base + i, 0);
    ENTRY_VALID_I = 1'b0;
  endtask
  // wait for all frames, then judge order and completion
  task automatic drain();
    int w;
    w = 0;
    while (net.ids.size() < exp_ids.size()) begin
      if (++w > 6000) give_up();
      tick();
    end
    tick(4);
    check("count", net.ids.size(), exp_ids.size());
    for (int i = nexp; i < exp_ids.size(); i++) begin
      check("frame_id", net.ids[i], exp_ids[i]);
      check("frame_data", net.dat[i], exp_dat[i]);
      check("frame_len", net.lens[i], 8'h08);
    end
    nexp = exp_ids.size();
    check("done", TX_DONE_FLAG_O, 1);
  endtask
  task automatic t_reset();
    tick(10);
    SRST_I = 1'b0;
    tick(2);
    check("mode", TX_PACING_SELECT_O, MODE_IMMEDIATE);
    check("free", FREE_ENTRY_COUNT_O, 1024);
    check("space", BATCH_SPACE_FLAG_O, 1);
    check("done_rst", TX_DONE_FLAG_O, 0);
  endtask
  task automatic t_immediate();
    stall = 1'b0;
    req(4, STAT_OK);
    put(KIND_PAYLOAD, 1, 900);
    put(KIND_REQUEST, 2, 5);
    put(KIND_PAYLOAD, 3, 700);
    // unknown kind is consumed and never sent
    put(8'h02, 99, 0);
    ENTRY_VALID_I = 1'b0;
    drain();
    check("imm_span", net.tms[2] - net.tms[0] <= 12, 1);
  endtask
  task automatic t_stamped();
    TX_PACING_SELECT_I = MODE_TIMESTAMPED;
    tick(2);
    check("mode", TX_PACING_SELECT_O, MODE_TIMESTAMPED);
    req(3, STAT_OK);
    check("done_clr", TX_DONE_FLAG_O, 0);
    t0 = net.cyc;
    put(KIND_PAYLOAD, 4, 1000);
    put(KIND_PAYLOAD, 5, 1040);
    put(KIND_PAYLOAD, 6, 1010);
    ENTRY_VALID_I = 1'b0;
    drain();
    check("first_now", net.tms[3] - t0 <= 10, 1);
    d = net.tms[4] - net.tms[3];
    check("ts_gap", d >= 40 && d <= 48, 1);
    check("ts_back", net.tms[5] - net.tms[4] <= 8, 1);
  endtask
  task automatic t_marker();
    req(2, STAT_OK);
    t0 = net.cyc;
    put(KIND_START, 7, 0);
    put(KIND_PAYLOAD, 8, 30);
    ENTRY_VALID_I = 1'b0;
    drain();
    d = net.tms[6] - t0;
    check("marker_wait", d >= 30 && d <= 42, 1);
  endtask
  task automatic t_overflow();
    TX_PACING_SELECT_I = MODE_IMMEDIATE;
    stall = 1'b1;
    tick(2);
    req(512, STAT_OK);
    req(1, STAT_ERR_BUSY);
    for (int i = 0; i < 511; i++) put(KIND_PAYLOAD, 100 + i, 0);
    // busy pulse on the edge that takes the last owed entry
    BATCH_START_I = 1'b1;
    put(KIND_PAYLOAD, 611, 0);
    BATCH_START_I = 1'b0;
    ENTRY_VALID_I = 1'b0;
    check("busy_valid", BATCH_STATUS_VALID_O, 1);
    check("busy_mid", BATCH_STATUS_O, STAT_ERR_BUSY);
    tick();
    req(512, STAT_WARN_LOW);
    feed(512, 612);
    tick(2);
    check("space_low", BATCH_SPACE_FLAG_O, 0);
    f = FREE_ENTRY_COUNT_O;
    req(512, STAT_ERR_OVFL);
    check("free_kept", FREE_ENTRY_COUNT_O, f);
    req(0, STAT_ERR_SIZE);
    req(513, STAT_ERR_SIZE);
    check("no_entry", ENTRY_READY_O, 0);
    stall = 1'b0;
    drain();
    check("space_back", BATCH_SPACE_FLAG_O, 1);
    req(512, STAT_OK);
    feed(512, 1200);
    drain();
  endtask
  initial begin
    t_reset();
    t_immediate();
    t_stamped();
    t_marker();
    t_overflow();
    finish_test();
  end
endmodule
